/* fdcr_pkg.sv */
/*
 * constants, register map and field layout of the flash driver control bank.
 * assumes an 8-bit register file behind a two-wire target at one device address.
 */
// Behaviour
// - mode bit 7 enables transmit-sync pin, default on
// - mode bit 6 picks level or edge trigger
// - infrared mode always uses level trigger
// - mode bit 5 gates the trigger pin
// - mode bit 4 gates torch/thermistor pin
// - mode bits 3:2 select standby/infrared/torch/flash
// - bit 1 turns second source on
// - bit 0 turns first source on
// - register torch/flash ignores both pins
// - standby: external flash beats external torch
// - infrared timeout turns off, mode back standby
// - target address 0x63, then register byte
package fdcr_pkg;

	localparam logic [6:0] DEV_ADDR = 7'h63;

	// =========================================================
	// register offsets
	localparam logic [7:0] A_MODE  = 8'h01;
	localparam logic [7:0] A_VMON  = 8'h02;
	localparam logic [7:0] A_FL1   = 8'h03;
	localparam logic [7:0] A_FL2   = 8'h04;
	localparam logic [7:0] A_TO1   = 8'h05;
	localparam logic [7:0] A_TO2   = 8'h06;
	localparam logic [7:0] A_CONV  = 8'h07;
	localparam logic [7:0] A_TIMER = 8'h08;
	localparam logic [7:0] A_THERM = 8'h09;
	localparam logic [7:0] A_FLAG1 = 8'h0a;
	localparam logic [7:0] A_FLAG2 = 8'h0b;
	localparam logic [7:0] A_IDENT = 8'h0c;
	localparam logic [7:0] A_LAST  = 8'h0d;

	// =========================================================
	// reset values
	localparam logic [7:0] R_MODE  = 8'h80;
	localparam logic [7:0] R_VMON  = 8'h01;
	localparam logic [7:0] R_LEVEL = 8'h7f;
	localparam logic [7:0] R_CONV  = 8'h09;
	localparam logic [7:0] R_TIMER = 8'h1a;
	localparam logic [7:0] R_THERM = 8'h08;
	localparam logic [7:0] R_ZERO  = 8'h00;
	// writable bits; reserved bits read zero
	localparam logic [7:0] M_FULL  = 8'hff;
	localparam logic [7:0] M_CONV  = 8'h8f;
	localparam logic [7:0] M_LOW7  = 8'h7f;

	// =========================================================
	// field positions
	localparam int B_TX    = 7;
	localparam int B_STYPE = 6;
	localparam int B_SEN   = 5;
	localparam int B_TEN   = 4;
	localparam int B_MODEH = 3;
	localparam int B_MODEL = 2;
	localparam int B_EN2   = 1;
	localparam int B_EN1   = 0;
	localparam int B_SRST  = 7;
	localparam int B_TPOL  = 6;
	localparam int B_TSEL  = 0;

	localparam logic [1:0] MODE_STANDBY  = 2'h0;
	localparam logic [1:0] MODE_INFRARED = 2'h1;
	localparam logic [1:0] MODE_TORCH    = 2'h2;
	localparam logic [1:0] MODE_FLASH    = 2'h3;

	typedef enum logic [2:0] {
		FN_OFF,
		FN_EXT_TORCH,
		FN_EXT_FLASH,
		FN_INFRARED_STANDBY,
		FN_INFRARED_ON,
		FN_INT_TORCH,
		FN_INT_FLASH
	} fdcr_func_type;

	function automatic logic [7:0] reset_value(input logic [7:0] a);
		case (a)
			A_MODE:  reset_value = R_MODE;
			A_VMON:  reset_value = R_VMON;
			A_CONV:  reset_value = R_CONV;
			A_TIMER: reset_value = R_TIMER;
			A_THERM: reset_value = R_THERM;
			A_FL1, A_FL2, A_TO1, A_TO2: reset_value = R_LEVEL;
			default: reset_value = R_ZERO;
		endcase
	endfunction

	function automatic logic [7:0] write_mask(input logic [7:0] a);
		case (a)
			A_MODE, A_VMON, A_FL1, A_FL2, A_TO1, A_TO2: write_mask = M_FULL;
			A_CONV:  write_mask = M_CONV;
			A_TIMER, A_THERM: write_mask = M_LOW7;
			default: write_mask = R_ZERO;
		endcase
	endfunction

endpackage

/* fdcr_i2c_target.sv */
/*
 * two-wire target: device address, register pointer, auto-incremented data bytes.
 * assumes scl and sda are already synchronous to mclk; sda is open drain.
 */
`timescale 1ns/10ps
module fdcr_i2c_target
	import fdcr_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       sys_rst,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	output logic [7:0]      reg_addr,
	input  wire logic [7:0] reg_rdata,
	output logic            wr_stb,
	output logic [7:0]      wr_data
);
	typedef enum logic [2:0] {ST_IDLE, ST_DEV, ST_REG, ST_WR, ST_RD} fdcr_bus_type;

	fdcr_bus_type st_q, st_d;
	logic [3:0]   cnt_q, cnt_d;
	logic [7:0]   rx_q, rx_d, tx_q, tx_d, ptr_q, ptr_d;
	logic         scl_q, sda_q, ack_q, ack_d, load_q, load_d, wr_d, wr_q;
	logic         start, stop, rise, fall;

	assign start    = scl_in & scl_q & sda_q & ~sda_in;
	assign stop     = scl_in & scl_q & ~sda_q & sda_in;
	assign rise     = scl_in & ~scl_q;
	assign fall     = ~scl_in & scl_q;
	assign sda_out  = 1'b0;
	// last read bit stands until the scl fall after it
	assign sda_oe   = ack_q | (st_q == ST_RD && !load_q && !tx_q[7]
	                  && (cnt_q < 4'h8 || (cnt_q == 4'h8 && scl_q)));
	assign reg_addr = ptr_q;
	assign wr_stb   = wr_q;
	assign wr_data  = rx_q;

	// =========================================================
	// byte and acknowledge sequencing
	always_comb
	begin
		st_d   = st_q;
		cnt_d  = cnt_q;
		rx_d   = rx_q;
		tx_d   = tx_q;
		ptr_d  = ptr_q;
		ack_d  = ack_q;
		load_d = load_q;
		wr_d   = 1'b0;
		if (start)
		begin
			st_d  = ST_DEV;
			cnt_d = 4'h0;
			ack_d = 1'b0;
		end
		else if (stop)
		begin
			st_d  = ST_IDLE;
			ack_d = 1'b0;
		end
		else if (st_q != ST_IDLE && rise)
		begin
			if (cnt_q < 4'h8)
			begin
				rx_d  = {rx_q[6:0], sda_in};
				cnt_d = cnt_q + 4'h1;
			end
			else if (st_q == ST_RD && !ack_q)
			begin
				// master nack ends the read
				if (sda_in)
					st_d = ST_IDLE;
				else
				begin
					ptr_d  = ptr_q + 8'h01;
					cnt_d  = 4'h0;
					load_d = 1'b1;
				end
			end
		end
		else if (st_q != ST_IDLE && fall)
		begin
			if (load_q)
			begin
				tx_d   = reg_rdata;
				load_d = 1'b0;
			end
			else if (cnt_q < 4'h8)
			begin
				if (st_q == ST_RD && cnt_q != 4'h0)
					tx_d = {tx_q[6:0], 1'b0};
			end
			else if (ack_q)
			begin
				ack_d = 1'b0;
				cnt_d = 4'h0;
				case (st_q)
					ST_DEV:
					begin
						st_d = rx_q[0] ? ST_RD : ST_REG;
						tx_d = reg_rdata;
					end
					ST_REG:  st_d = ST_WR;
					ST_WR:   ptr_d = ptr_q + 8'h01;
					default: st_d = st_q;
				endcase
			end
			else if (st_q != ST_RD)
			begin
				case (st_q)
					ST_DEV:
					begin
						if (rx_q[7:1] == DEV_ADDR)
							ack_d = 1'b1;
						else
							st_d = ST_IDLE;
					end
					ST_REG:
					begin
						ptr_d = rx_q;
						ack_d = 1'b1;
					end
					ST_WR:
					begin
						wr_d  = 1'b1;
						ack_d = 1'b1;
					end
					default: ack_d = 1'b0;
				endcase
			end
		end
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			st_q   <= ST_IDLE;
			cnt_q  <= 4'h0;
			rx_q   <= 8'h00;
			tx_q   <= 8'hff;
			ptr_q  <= 8'h00;
			ack_q  <= 1'b0;
			load_q <= 1'b0;
			wr_q   <= 1'b0;
			scl_q  <= 1'b1;
			sda_q  <= 1'b1;
		end
		else
		begin
			st_q   <= st_d;
			cnt_q  <= cnt_d;
			rx_q   <= rx_d;
			tx_q   <= tx_d;
			ptr_q  <= ptr_d;
			ack_q  <= ack_d;
			load_q <= load_d;
			wr_q   <= wr_d;
			scl_q  <= scl_in;
			sda_q  <= sda_in;
		end
	end

endmodule // fdcr_i2c_target

/* fdcr_regs.sv */
/*
 * control register bank of the dual-source flash driver with pin arbitration.
 * assumes pins and the timeout pulse are synchronous to mclk.
 */
`timescale 1ns/10ps
module fdcr_regs
	import fdcr_pkg::*;
#(
	parameter logic [7:0] IDENT_VALUE = 8'h2a // arbitrary identification value
)
(
	input  wire logic    mclk,
	input  wire logic    sys_rst,
	input  wire logic    hardware_enable_pin,
	input  wire logic    scl_in,
	input  wire logic    sda_in,
	output logic         sda_out,
	output logic         sda_oe,
	input  wire logic    strobe_pin,
	input  wire logic    torch_pin,
	input  wire logic    timeout_pulse,
	input  wire logic [7:0] fault_flags_one_in,
	input  wire logic [7:0] fault_flags_two_in,
	input  wire logic [7:0] last_level_in,
	output logic         tx_pin_enable,
	output fdcr_func_type function_state,
	output logic         first_source_on,
	output logic         second_source_on,
	output logic [7:0]   first_source_level,
	output logic [7:0]   second_source_level,
	output logic [7:0]   input_voltage_monitor_config,
	output logic [7:0]   converter_config,
	output logic [7:0]   timer_config,
	output logic [7:0]   thermistor_config
);
	logic [7:0]    regs_q [1:9];
	logic [7:0]    regs_d [1:9];
	logic [7:0]    reg_addr, reg_rdata, wr_data;
	logic          wr_stb;
	logic          strobe_prev_q, strobe_prev_d;
	logic          edge_lat_q, edge_lat_d;
	logic          timed_out_q, timed_out_d;
	fdcr_func_type func_q, func_d;
	logic          src1_q, src1_d, src2_q, src2_d;
	logic [7:0]    lvl1_q, lvl1_d, lvl2_q, lvl2_d;
	logic [7:0]    mode_r;
	logic [1:0]    opmode;
	logic          strobe_act, torch_act, flash_req, soft_rst;

	fdcr_i2c_target u_target (
		.mclk      (mclk),
		.sys_rst   (sys_rst),
		.scl_in    (scl_in),
		.sda_in    (sda_in),
		.sda_out   (sda_out),
		.sda_oe    (sda_oe),
		.reg_addr  (reg_addr),
		.reg_rdata (reg_rdata),
		.wr_stb    (wr_stb),
		.wr_data   (wr_data)
	);

	assign mode_r     = regs_q[1];
	assign opmode     = mode_r[B_MODEH:B_MODEL];
	assign strobe_act = mode_r[B_SEN] & strobe_pin;
	assign torch_act  = mode_r[B_TEN] & !regs_q[9][B_TSEL]
	                  & (torch_pin ^ regs_q[9][B_TPOL]);
	assign soft_rst   = wr_stb && reg_addr == A_CONV && wr_data[B_SRST];

	assign tx_pin_enable       = mode_r[B_TX];
	assign function_state      = func_q;
	assign first_source_on     = src1_q;
	assign second_source_on    = src2_q;
	assign first_source_level  = lvl1_q;
	assign second_source_level = lvl2_q;
	assign input_voltage_monitor_config = regs_q[2];
	assign converter_config    = regs_q[7];
	assign timer_config        = regs_q[8];
	assign thermistor_config   = regs_q[9];

	// =========================================================
	// read mux
	always_comb
	begin
		case (reg_addr)
			A_MODE, A_VMON, A_FL1, A_FL2, A_TO1, A_TO2, A_CONV, A_TIMER, A_THERM:
				reg_rdata = regs_q[reg_addr[3:0]];
			A_FLAG1: reg_rdata = fault_flags_one_in;
			A_FLAG2: reg_rdata = fault_flags_two_in;
			A_IDENT: reg_rdata = IDENT_VALUE;
			A_LAST:  reg_rdata = last_level_in;
			default: reg_rdata = R_ZERO;
		endcase
	end

	// =========================================================
	// trigger tracking and function selection
	always_comb
	begin
		strobe_prev_d = strobe_act;
		edge_lat_d    = edge_lat_q;
		timed_out_d   = timed_out_q;
		for (int i = 1; i <= 9; i++)
		begin
			regs_d[i] = regs_q[i];
		end
		if (wr_stb && write_mask(reg_addr) != R_ZERO)
			regs_d[reg_addr[3:0]] = wr_data & write_mask(reg_addr);
		// soft reset bit clears itself with the defaults
		if (soft_rst)
		begin
			for (int i = 1; i <= 9; i++)
			begin
				regs_d[i] = reset_value(8'(i));
			end
		end
		// level trigger: timeout holds off until the pin goes inactive
		if (!strobe_act)
			timed_out_d = 1'b0;
		else if (timeout_pulse)
			timed_out_d = 1'b1;
		// edge trigger latches on a rising edge and ends at timeout
		if (mode_r[B_STYPE] && opmode == MODE_STANDBY)
		begin
			if (strobe_act && !strobe_prev_q)
				edge_lat_d = 1'b1;
			else if (timeout_pulse || !mode_r[B_SEN])
				edge_lat_d = 1'b0;
		end
		else
			edge_lat_d = 1'b0;
		flash_req = mode_r[B_STYPE] ? edge_lat_q : (strobe_act && !timed_out_q);
		case (opmode)
			MODE_STANDBY:
			begin
				if (flash_req)
					func_d = FN_EXT_FLASH;
				else if (torch_act)
					func_d = FN_EXT_TORCH;
				else
					func_d = FN_OFF;
			end
			MODE_INFRARED:
			begin
				// level trigger only, type bit ignored
				if (strobe_act && !timed_out_q)
					func_d = FN_INFRARED_ON;
				else
					func_d = FN_INFRARED_STANDBY;
				if (strobe_act && timeout_pulse && !soft_rst)
				begin
					func_d = FN_OFF;
					regs_d[1][B_MODEH:B_MODEL] = MODE_STANDBY;
				end
			end
			MODE_TORCH: func_d = FN_INT_TORCH;
			MODE_FLASH: func_d = FN_INT_FLASH;
			default:    func_d = FN_OFF;
		endcase
		src1_d = 1'b0;
		src2_d = 1'b0;
		lvl1_d = regs_q[5];
		lvl2_d = regs_q[6];
		case (func_d)
			FN_EXT_TORCH, FN_INT_TORCH:
			begin
				src1_d = mode_r[B_EN1];
				src2_d = mode_r[B_EN2];
			end
			FN_EXT_FLASH, FN_INFRARED_ON, FN_INT_FLASH:
			begin
				src1_d = mode_r[B_EN1];
				src2_d = mode_r[B_EN2];
				lvl1_d = regs_q[3];
				lvl2_d = regs_q[4];
			end
			default:
			begin
				src1_d = 1'b0;
				src2_d = 1'b0;
			end
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst || !hardware_enable_pin)
		begin
			for (int i = 1; i <= 9; i++)
			begin
				regs_q[i] <= reset_value(8'(i));
			end
			strobe_prev_q <= 1'b0;
			edge_lat_q    <= 1'b0;
			timed_out_q   <= 1'b0;
			func_q        <= FN_OFF;
			src1_q        <= 1'b0;
			src2_q        <= 1'b0;
			lvl1_q        <= R_LEVEL;
			lvl2_q        <= R_LEVEL;
		end
		else
		begin
			for (int i = 1; i <= 9; i++)
			begin
				regs_q[i] <= regs_d[i];
			end
			strobe_prev_q <= strobe_prev_d;
			edge_lat_q    <= edge_lat_d;
			timed_out_q   <= timed_out_d;
			func_q        <= func_d;
			src1_q        <= src1_d;
			src2_q        <= src2_d;
			lvl1_q        <= lvl1_d;
			lvl2_q        <= lvl2_d;
		end
	end

endmodule // fdcr_regs

/* fdcr_asserts.sv */
/* checker: port relations of fdcr_regs.
   assumes a single mclk domain; bound into fdcr_regs below. */
`timescale 1ns/10ps
module fdcr_asserts
	import fdcr_pkg::*;
(
	input wire logic          mclk,
	input wire logic          sys_rst,
	input wire logic          hardware_enable_pin,
	input wire logic          scl_in,
	input wire logic          strobe_pin,
	input wire logic          timeout_pulse,
	input wire logic          sda_out,
	input wire logic          sda_oe,
	input wire logic          tx_pin_enable,
	input wire fdcr_func_type function_state,
	input wire logic          first_source_on,
	input wire logic          second_source_on,
	input wire logic [7:0]    first_source_level,
	input wire logic [7:0]    input_voltage_monitor_config
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (sys_rst);
	// =====================================
	// assertions
	sequence s_infrared_expire;
		function_state == FN_INFRARED_ON && strobe_pin && scl_in && timeout_pulse;
	endsequence
	sequence s_cleared;
		tx_pin_enable && function_state == FN_OFF && input_voltage_monitor_config == R_VMON
		&& first_source_level == R_LEVEL;
	endsequence
	a_open_drain: assert property (sda_out == 1'b0)
		else $error("sda value not low");
	a_ack_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
		else $error("sda moved while scl high");
	a_pin_defaults: assert property (!hardware_enable_pin |=> s_cleared)
		else $error("defaults not restored");
	a_idle_sources_off: assert property (function_state inside {FN_OFF, FN_INFRARED_STANDBY} |->
		!first_source_on && !second_source_on)
		else $error("source lit while idle");
	a_infrared_level_only: assert property (function_state == FN_INFRARED_ON |-> $past(strobe_pin))
		else $error("infrared lit without strobe");
	a_infrared_timeout_off: assert property (s_infrared_expire |=> function_state == FN_OFF)
		else $error("infrared timeout ignored");
	a_tx_bus_only: assert property ($changed(tx_pin_enable) && $past(hardware_enable_pin) |-> !scl_in)
		else $error("tx enable moved off a write");
	a_int_mode_holds: assert property (function_state inside {FN_INT_TORCH, FN_INT_FLASH} && scl_in
		&& hardware_enable_pin && !timeout_pulse |=> $stable(function_state))
		else $error("register mode left by pins");
endmodule // fdcr_asserts

bind fdcr_regs fdcr_asserts i_chk (
	.mclk(mclk), .sys_rst(sys_rst), .hardware_enable_pin(hardware_enable_pin),
	.scl_in(scl_in), .strobe_pin(strobe_pin), .timeout_pulse(timeout_pulse),
	.sda_out(sda_out), .sda_oe(sda_oe), .tx_pin_enable(tx_pin_enable),
	.function_state(function_state), .first_source_on(first_source_on),
	.second_source_on(second_source_on), .first_source_level(first_source_level),
	.input_voltage_monitor_config(input_voltage_monitor_config)
);

/* fdcr_host.sv */
/* two-wire host model: start, stop, byte out, byte in.
   assumes the bench forms the wire from all pulls with a pull-up. */
`timescale 1ns/10ps
module fdcr_host
(
	input  wire logic mclk,
	input  wire logic sda_wire,
	output logic      scl,
	output logic      pull_low
);
	initial
	begin
		scl = 1'b1;
		pull_low = 1'b0;
	end
	// every bus level lasts four mclk cycles
	task automatic step(input logic c, input logic p);
		@(posedge mclk);
		scl <= c;
		pull_low <= p;
		repeat (3) @(posedge mclk);
	endtask
	task automatic bit_io(input logic b, output logic r);
		step(1'b0, !b);
		step(1'b1, !b);
		r = sda_wire;
	endtask
	task automatic start();
		step(1'b0, 1'b0);
		step(1'b1, 1'b0);
		step(1'b1, 1'b1);
	endtask
	task automatic stop();
		step(1'b0, 1'b1);
		step(1'b1, 1'b1);
		step(1'b1, 1'b0);
	endtask
	task automatic put(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r);
		bit_io(1'b1, ack);
	endtask
	task automatic get(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, d[i]);
		bit_io(last, r);
	endtask
endmodule // fdcr_host

/* fdcr_regs_test.sv */
/* self-checking bench for fdcr_regs.
   assumes fdcr_pkg, fdcr_host and the bound checker. */
`timescale 1ns/10ps
module fdcr_regs_test
	import fdcr_pkg::*;
();
	logic          mclk;
	logic          sys_rst;
	logic          hw_enable;
	logic          strobe;
	logic          torch;
	logic          tmo;
	logic          scl;
	logic          host_low;
	logic          sda_out;
	logic          sda_oe;
	logic          tx_en;
	fdcr_func_type fn;
	logic          on1;
	logic          on2;
	logic [7:0]    lvl1;
	logic [7:0]    lvl2;
	int            failures;
	int            total_checks;
	logic [7:0]    vmon_cfg;
	logic [7:0]    conv_cfg;
	logic [7:0]    timer_cfg;
	logic [7:0]    therm_cfg;
	// host holds an edge trigger pulse just over 1ms
	localparam int TRIG_MIN_CYCLES = 50001;
	wire           sda_wire = !((sda_oe && !sda_out) || host_low);
	// identification value 8'h4b is arbitrary
	fdcr_regs #(.IDENT_VALUE(8'h4b)) i_dut (
		.mclk(mclk), .sys_rst(sys_rst), .hardware_enable_pin(hw_enable), .scl_in(scl),
		.sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe), .strobe_pin(strobe),
		.torch_pin(torch), .timeout_pulse(tmo), .fault_flags_one_in(8'h5a),
		.fault_flags_two_in(8'ha5), .last_level_in(8'h3c), .tx_pin_enable(tx_en),
		.function_state(fn), .first_source_on(on1), .second_source_on(on2),
		.first_source_level(lvl1), .second_source_level(lvl2), .input_voltage_monitor_config(vmon_cfg),
		.converter_config(conv_cfg), .timer_config(timer_cfg), .thermistor_config(therm_cfg)
	);
	fdcr_host i_host (.mclk(mclk), .sda_wire(sda_wire), .scl(scl), .pull_low(host_low));
	initial
	begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic head(input logic [7:0] a);
		logic k;
		i_host.start();
		i_host.put({DEV_ADDR, 1'b0}, k);
		check("address ack", {7'h0, k}, 8'h00);
		i_host.put(a, k);
		check("pointer ack", {7'h0, k}, 8'h00);
	endtask
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		logic k;
		head(a);
		i_host.put(d, k);
		i_host.stop();
	endtask
	task automatic expect_reg(input logic [7:0] a, input logic [7:0] e);
		logic       k;
		logic [7:0] d;
		head(a);
		i_host.start();
		i_host.put({DEV_ADDR, 1'b1}, k);
		i_host.get(1'b1, d);
		i_host.stop();
		check("register", d, e);
	endtask
	task automatic pins(input logic s, input logic t, input logic p);
		@(posedge mclk);
		strobe <= s;
		torch <= t;
		tmo <= p;
		@(posedge mclk);
		tmo <= 1'b0;
		repeat (2) @(posedge mclk);
	endtask
	task automatic outs(input fdcr_func_type f, input logic [1:0] on);
		@(negedge mclk);
		check("function", {5'h0, fn}, {5'h0, f});
		check("sources", {6'h0, on2, on1}, {6'h0, on});
	endtask
	// =====================================
	// scenarios
	task automatic t_defaults();
		logic [7:0] tbl [13] = '{8'h80, 8'h01, 8'h7f, 8'h7f, 8'h7f, 8'h7f, 8'h09,
			8'h1a, 8'h08, 8'h5a, 8'ha5, 8'h4b, 8'h3c};
		for (int a = 1; a <= 13; a++)
			expect_reg(8'(a), tbl[a - 1]);
		outs(FN_OFF, 2'h0);
		check("tx enable", {7'h0, tx_en}, 8'h01);
		check("vmon cfg", vmon_cfg, 8'h01);
		check("converter cfg", conv_cfg, 8'h09);
		check("timer cfg", timer_cfg, 8'h1a);
		check("thermistor cfg", therm_cfg, 8'h08);
	endtask
	task automatic t_access();
		logic k;
		i_host.start();
		i_host.put({7'h62, 1'b0}, k);
		check("foreign ack", {7'h0, k}, 8'h01);
		i_host.stop();
		wreg(8'h07, 8'h7f);
		expect_reg(8'h07, 8'h0f);
		check("converter cfg", conv_cfg, 8'h0f);
		wreg(8'h08, 8'hff);
		expect_reg(8'h08, 8'h7f);
		check("timer cfg", timer_cfg, 8'h7f);
		wreg(8'h0a, 8'h00);
		wreg(8'h20, 8'h55);
		expect_reg(8'h0a, 8'h5a);
	endtask
	task automatic t_modes();
		fdcr_func_type f [4] = '{FN_OFF, FN_INFRARED_STANDBY, FN_INT_TORCH, FN_INT_FLASH};
		logic          k;
		logic [7:0]    v;
		head(8'h03);
		i_host.put(8'h31, k);
		i_host.put(8'h32, k);
		i_host.put(8'h51, k);
		i_host.put(8'h52, k);
		i_host.stop();
		for (int m = 0; m < 4; m++)
		begin
			v = {m[0], 3'b011, m[1:0], 2'b11};
			wreg(8'h01, v);
			pins(m[1], m[1], 1'b0);
			expect_reg(8'h01, v);
			outs(f[m], {2{m[1]}});
			check("tx enable", {7'h0, tx_en}, {7'h0, m[0]});
			if (m[1])
			begin
				check("level one", lvl1, m[0] ? 8'h31 : 8'h51);
				check("level two", lvl2, m[0] ? 8'h32 : 8'h52);
			end
		end
		pins(1'b0, 1'b0, 1'b0);
	endtask
	task automatic t_external();
		wreg(8'h01, 8'hb3);
		pins(1'b0, 1'b1, 1'b0);
		outs(FN_EXT_TORCH, 2'h3);
		pins(1'b1, 1'b1, 1'b0);
		outs(FN_EXT_FLASH, 2'h3);
		check("flash level", lvl1, 8'h31);
		wreg(8'h01, 8'h93);
		outs(FN_EXT_TORCH, 2'h3);
		wreg(8'h01, 8'h81);
		outs(FN_OFF, 2'h0);
		wreg(8'h01, 8'h91);
		outs(FN_EXT_TORCH, 2'h1);
		wreg(8'h09, 8'h09);
		outs(FN_OFF, 2'h0);
		wreg(8'h09, 8'h48);
		check("thermistor cfg", therm_cfg, 8'h48);
		pins(1'b0, 1'b0, 1'b0);
		outs(FN_EXT_TORCH, 2'h1);
		wreg(8'h09, 8'h08);
		pins(1'b0, 1'b0, 1'b0);
	endtask
	task automatic t_infrared();
		wreg(8'h01, 8'h43);
		wreg(8'h01, 8'he7);
		pins(1'b1, 1'b0, 1'b0);
		outs(FN_INFRARED_ON, 2'h3);
		pins(1'b0, 1'b0, 1'b0);
		outs(FN_INFRARED_STANDBY, 2'h0);
		pins(1'b1, 1'b0, 1'b0);
		pins(1'b1, 1'b0, 1'b1);
		outs(FN_OFF, 2'h0);
		expect_reg(8'h01, 8'he3);
		pins(1'b0, 1'b0, 1'b0);
	endtask
	task automatic t_edge();
		pins(1'b1, 1'b0, 1'b0);
		repeat (TRIG_MIN_CYCLES) @(posedge mclk);
		pins(1'b0, 1'b0, 1'b0);
		outs(FN_EXT_FLASH, 2'h3);
		pins(1'b0, 1'b0, 1'b1);
		outs(FN_OFF, 2'h0);
		wreg(8'h01, 8'h00);
	endtask
	task automatic t_reset();
		wreg(8'h02, 8'h55);
		expect_reg(8'h02, 8'h55);
		check("vmon cfg", vmon_cfg, 8'h55);
		@(posedge mclk);
		hw_enable <= 1'b0;
		repeat (2) @(posedge mclk);
		hw_enable <= 1'b1;
		expect_reg(8'h02, 8'h01);
		expect_reg(8'h01, 8'h80);
		wreg(8'h05, 8'h99);
		wreg(8'h07, 8'h80);
		expect_reg(8'h05, 8'h7f);
		expect_reg(8'h07, 8'h09);
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial
	begin
		failures = 0;
		total_checks = 0;
		sys_rst = 1'b1;
		hw_enable = 1'b1;
		strobe = 1'b0;
		torch = 1'b0;
		tmo = 1'b0;
		repeat (16) @(posedge mclk);
		sys_rst <= 1'b0;
		t_defaults();
		t_access();
		t_modes();
		t_external();
		t_infrared();
		t_edge();
		t_reset();
		close_out();
	end
	// about one and a half times the expected run
	initial
	begin
		#2000000;
		failures++;
		close_out();
	end
endmodule // fdcr_regs_test
